// ===== src/psl_params.svh
// constants for the pid sleep / limit supervisor: offsets, resets, timing
// assumes a 125 MHz clk and a 0.1 s control tick derived from it
//
// Behaviour
// - sleep starts when the pid output or frequency command stays below the sleep start level (default 0.0 Hz) longer than the sleep delay.
// - the sleep delay (up to 25.5 s) governs entering and leaving sleep, and a delay of zero disables sleep.
// - on sleep the motor is stopped with the currently selected stopping method.
// - the sleep start level is clamped to the lower of maximum output frequency and the command upper limit.
// - the target ramps with its own ramp time of 0.0 to 20.0 s, bypassed when an input is assigned soft-start code 49.
// - with target source select 1 and no analog target input, the fixed target of 0.00 to 100.00 percent is used.
// - the units code selects 0.01 Hz, percent, r/min or user scaling for 0 to 3, and resets to 1.
// - the pid output lower limit lies within -100 to 100 percent of maximum frequency and zero disables it.
// - the pid input is clamped to plus and minus the input limit, up to and defaulting to 1000 percent.
// - feedback high is flagged when feedback stays above the high level (default 100 percent) longer than the high time (default 1.0 s).
// - display full scale (1 to 60000) and decimals (0 to 3) are writable only while the units code is 3.
// - while pid is active the monitor shows the corrected reference for select 0 and the raw reference for select 1.
// - with reverse select 2 at 0 a negative pid output is clamped to zero and stops output, at 1 (reset) it reverses.
// - in trim modes 3 and 4 reverse select 2 has no effect and the pid output is not limited.
// - when reverse running is prohibited, reverse select 2 is ignored and negative output never reverses.
// - in detection mode 0 the code 41 output follows feedback high, with no alarm, and releases on return to normal.
`ifndef PSL_PARAMS_SVH
`define PSL_PARAMS_SVH

// register byte offsets
`define PSL_OFF_SLEEP_LVL 8'h00
`define PSL_OFF_SLEEP_DLY 8'h04
`define PSL_OFF_STOP_CFG 8'h08
`define PSL_OFF_RAMP 8'h0C
`define PSL_OFF_TGT_SRC 8'h10
`define PSL_OFF_FIXED_TGT 8'h14
`define PSL_OFF_UNITS 8'h18
`define PSL_OFF_LOW_LIM 8'h1C
`define PSL_OFF_IN_LIM 8'h20
`define PSL_OFF_FBH_LVL 8'h24
`define PSL_OFF_FBH_TIME 8'h28
`define PSL_OFF_DISP_FULL 8'h2C
`define PSL_OFF_DISP_DEC 8'h30
`define PSL_OFF_MON_SEL 8'h34
`define PSL_OFF_REV_SEL2 8'h38
`define PSL_OFF_MODE 8'h3C
`define PSL_OFF_MAX_FREQ 8'h40
`define PSL_OFF_UPPER 8'h44
`define PSL_OFF_STATUS 8'h48
`define PSL_OFF_TGT_MON 8'h4C
`define PSL_OFF_FREQ_MON 8'h50

// field positions
`define PSL_F_REV_PROHIBIT 2
`define PSL_F_TGT_SEL 0
`define PSL_F_ANA_TGT 1
`define PSL_F_SOFT_DI 2
`define PSL_F_FB_MODE 4
`define PSL_F_REFUSED 4

// reset values
`define PSL_RST_UNITS 2'h1
`define PSL_RST_IN_LIM 16'h2710
`define PSL_RST_FBH_LVL 8'h64
`define PSL_RST_FBH_TIME 8'h0A
`define PSL_RST_REV_SEL2 1'h1
`define PSL_RST_MAX_FREQ 16'h1770
`define PSL_RST_UPPER 16'h1770
`define PSL_RST_DISP_FULL 16'h2710
`define PSL_RST_DISP_DEC 2'h2

// ranges and encodings
`define PSL_RAMP_MAX 8'hC8
`define PSL_PCT_FULL 16'h2710
`define PSL_LOW_LIM_MAX 16'h03E8
`define PSL_IN_LIM_MAX 16'h2710
`define PSL_IN_LIM_SCALE 18'h0_000A
`define PSL_FBH_LVL_MAX 8'h64
`define PSL_FBH_SCALE 16'h0064
`define PSL_DISP_FULL_MAX 16'hEA60
`define PSL_UNITS_USER 2'h3
`define PSL_MODE_TRIM_A 3'h3
`define PSL_MODE_TRIM_B 3'h4
`define PSL_FB_MODE_MFO 3'h0
`define PSL_PERMILLE 33'h0_0000_03E8

// control tick: 0.1 s at 125 MHz
`define PSL_TICK_MS 100
`define PSL_CLK_KHZ 125000
`define PSL_TICK_CYCLES (`PSL_TICK_MS * `PSL_CLK_KHZ)

`endif

// ===== src/psl_pkg.sv
// types shared by the supervisor and its qualification timer
// assumes psl_params.svh supplies the numeric constants
`default_nettype none

package psl_pkg;

  typedef enum logic {
    PSL_RUN = 1'b0,
    PSL_SLEEP = 1'b1
  } psl_sleep_t;

  typedef struct packed {
    logic [8:0] cnt;
  } psl_qual_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [23:0] tick_cnt;
    logic [15:0] sleep_lvl;
    logic [7:0] sleep_dly;
    logic [1:0] stop_meth;
    logic rev_prohibit;
    logic [7:0] ramp_time;
    logic tgt_sel;
    logic ana_tgt;
    logic soft_di;
    logic [15:0] fixed_tgt;
    logic [1:0] units;
    logic signed [15:0] low_lim;
    logic [15:0] in_lim;
    logic [7:0] fbh_lvl;
    logic [7:0] fbh_time;
    logic [15:0] disp_full;
    logic [1:0] disp_dec;
    logic mon_sel;
    logic rev_sel2;
    logic [2:0] pid_mode;
    logic [2:0] fb_mode;
    logic [15:0] max_freq;
    logic [15:0] upper;
    logic refused;
    psl_sleep_t sleep;
    logic fb_high;
    logic [15:0] tgt;
    logic signed [17:0] pid_in;
    logic [15:0] drive_hz;
    logic reverse;
    logic stop_req;
    logic [15:0] freq_mon;
  } psl_state_t;

endpackage : psl_pkg

`default_nettype wire

// ===== src/psl_qual_if.sv
// condition / limit / expiry bundle between the supervisor and a timer
// assumes all signals live on the supervisor clock
`default_nettype none

interface psl_qual_if;
  logic tick;
  logic cond;
  logic [7:0] limit;
  logic expired;

  modport timer (input tick, input cond, input limit, output expired);
  modport user (output tick, output cond, output limit, input expired);
endinterface : psl_qual_if

`default_nettype wire

// ===== src/psl_qual_timer.sv
// qualification timer: counts 0.1 s ticks while a condition holds
// assumes tick is a one-cycle enable and limit is in ticks
`default_nettype none

module psl_qual_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // condition and expiry
  psl_qual_if.timer q
);
  import psl_pkg::*;

  psl_qual_state_t cur, nxt;

  // "longer than": expiry needs one tick past the limit
  assign q.expired = q.cond && (cur.cnt > {1'b0, q.limit});

  always_comb begin
    nxt = cur;
    if (!q.cond) begin
      nxt.cnt = 9'h000;
    end else if (q.tick && (cur.cnt <= {1'b0, q.limit})) begin
      nxt.cnt = cur.cnt + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  timer_restart_a: assert property (!q.cond |=> cur.cnt == 9'h000)
    else $error("qualification count not cleared");

endmodule : psl_qual_timer

`default_nettype wire

// ===== src/psl_supervisor.sv
// pid sleep, target ramp, pid limits and feedback-high supervisor
// assumes pid math and frequency command come from logic on clk
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`include "psl_params.svh"
`default_nettype none

module psl_supervisor #(
  parameter int unsigned TICK_CYCLES = `PSL_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // process values (0.01 Hz, 0.1 % and 0.01 % of max frequency)
  input wire logic [15:0] freq_cmd,
  input wire logic signed [15:0] pid_out,
  input wire logic signed [15:0] feedback,
  input wire logic [15:0] analog_target,
  // controller side
  output logic [15:0] pid_target,
  output logic signed [17:0] pid_input,
  // drive side
  output logic [15:0] drive_freq,
  output logic drive_reverse,
  output logic stop_request,
  output logic [1:0] stop_method_select,
  output logic [15:0] freq_ref_monitor,
  output logic fb_high_output,
  // display encoding
  output logic [1:0] target_units_code,
  output logic [15:0] user_display_fullscale,
  output logic [1:0] user_display_decimals
);
  import psl_pkg::*;

  psl_state_t cur, nxt;
  psl_qual_if sq ();
  psl_qual_if fq ();

  logic [31:0] rd_val;
  logic [31:0] wr_val;
  logic tick, wr_go, trim, pid_act, rev_ok, neg, neg_stop;
  logic below, fb_cond, sleeping, sleep_en;
  logic signed [15:0] pid_lim;
  logic [16:0] mag;
  logic [32:0] prod;
  logic [15:0] cap, pid_hz, trim_hz, run_hz, lvl_eff, tgt_src, step;
  logic signed [17:0] err, in_lim_x;
  logic [16:0] trim_sum;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // one wait state: request seen, answer one cycle later
  assign avs_waitrequest = (avs_read || avs_write) && !cur.ack;
  assign wr_go = avs_write && cur.ack;
  assign tick = (cur.tick_cnt == 24'(TICK_CYCLES - 1));
  assign sleeping = (cur.sleep == PSL_SLEEP);

  always_comb begin
    case (avs_address)
      `PSL_OFF_SLEEP_LVL: rd_val = {16'h0000, cur.sleep_lvl};
      `PSL_OFF_SLEEP_DLY: rd_val = {24'h00_0000, cur.sleep_dly};
      `PSL_OFF_STOP_CFG: rd_val = {29'h0000_0000, cur.rev_prohibit,
                                   cur.stop_meth};
      `PSL_OFF_RAMP: rd_val = {24'h00_0000, cur.ramp_time};
      `PSL_OFF_TGT_SRC: rd_val = {29'h0000_0000, cur.soft_di, cur.ana_tgt,
                                  cur.tgt_sel};
      `PSL_OFF_FIXED_TGT: rd_val = {16'h0000, cur.fixed_tgt};
      `PSL_OFF_UNITS: rd_val = {30'h0000_0000, cur.units};
      `PSL_OFF_LOW_LIM: rd_val = {16'h0000, cur.low_lim};
      `PSL_OFF_IN_LIM: rd_val = {16'h0000, cur.in_lim};
      `PSL_OFF_FBH_LVL: rd_val = {24'h00_0000, cur.fbh_lvl};
      `PSL_OFF_FBH_TIME: rd_val = {24'h00_0000, cur.fbh_time};
      `PSL_OFF_DISP_FULL: rd_val = {16'h0000, cur.disp_full};
      `PSL_OFF_DISP_DEC: rd_val = {30'h0000_0000, cur.disp_dec};
      `PSL_OFF_MON_SEL: rd_val = {31'h0000_0000, cur.mon_sel};
      `PSL_OFF_REV_SEL2: rd_val = {31'h0000_0000, cur.rev_sel2};
      `PSL_OFF_MODE: rd_val = {25'h000_0000, cur.fb_mode, 1'b0,
                               cur.pid_mode};
      `PSL_OFF_MAX_FREQ: rd_val = {16'h0000, cur.max_freq};
      `PSL_OFF_UPPER: rd_val = {16'h0000, cur.upper};
      `PSL_OFF_STATUS: rd_val = {27'h000_0000, cur.refused, cur.stop_req,
                                 cur.reverse, cur.fb_high, sleeping};
      `PSL_OFF_TGT_MON: rd_val = {16'h0000, cur.tgt};
      `PSL_OFF_FREQ_MON: rd_val = {16'h0000, cur.freq_mon};
      default: rd_val = 32'h0000_0000;
    endcase
    wr_val = be_merge(rd_val, avs_writedata, avs_byteenable);
  end

  // datapath
  always_comb begin
    trim = (cur.pid_mode == `PSL_MODE_TRIM_A) ||
           (cur.pid_mode == `PSL_MODE_TRIM_B);
    pid_act = (cur.pid_mode != 3'h0);
    cap = (cur.max_freq < cur.upper) ? cur.max_freq : cur.upper;
    lvl_eff = (cur.sleep_lvl < cap) ? cur.sleep_lvl : cap;
    tgt_src = (cur.tgt_sel && !cur.ana_tgt) ? cur.fixed_tgt
                                             : analog_target;
    step = `PSL_PCT_FULL / ((cur.ramp_time == 8'h00) ? 16'h0001
                            : {8'h00, cur.ramp_time});
    err = $signed({2'b00, cur.tgt}) - $signed({{2{feedback[15]}}, feedback});
    in_lim_x = $signed(18'({2'b00, cur.in_lim} * `PSL_IN_LIM_SCALE));
    // trim modes pass the output untouched, otherwise lower limit applies
    pid_lim = pid_out;
    if (!trim && (cur.low_lim != 16'h0000) && (pid_out < cur.low_lim)) begin
      pid_lim = cur.low_lim;
    end
    neg = pid_lim < 16'sh0000;
    rev_ok = !trim && cur.rev_sel2 && !cur.rev_prohibit;
    neg_stop = !trim && neg && !rev_ok;
    mag = neg ? 17'(-$signed({pid_lim[15], pid_lim}))
              : {1'b0, pid_lim};
    if (neg_stop) begin
      mag = 17'h0_0000;
    end
    prod = 33'(({16'h0000, mag} * {17'h0_0000, cur.max_freq})
               / `PSL_PERMILLE);
    pid_hz = (prod > {17'h0_0000, cap}) ? cap : prod[15:0];
    // trim: pid correction added to or taken from the command
    if (neg) begin
      trim_sum = (freq_cmd > pid_hz) ? {1'b0, freq_cmd - pid_hz} : 17'h0_0000;
    end else begin
      trim_sum = {1'b0, freq_cmd} + {1'b0, pid_hz};
    end
    trim_hz = (trim_sum > {1'b0, cap}) ? cap : trim_sum[15:0];
    run_hz = !pid_act ? freq_cmd : (trim ? trim_hz : pid_hz);
    below = run_hz < lvl_eff;
    sleep_en = (cur.sleep_dly != 8'h00);
    fb_cond = $signed({feedback[15], feedback}) >
              $signed({1'b0, 16'(cur.fbh_lvl * `PSL_FBH_SCALE)});
  end

  assign sq.tick = tick;
  assign sq.limit = cur.sleep_dly;
  // same delay qualifies leaving sleep once the level comes back
  assign sq.cond = sleep_en && (sleeping ? !below : below);
  assign fq.tick = tick;
  assign fq.limit = cur.fbh_time;
  assign fq.cond = fb_cond;

  psl_qual_timer u_sleep_timer (
    .clk (clk),
    .rst (rst),
    .q (sq.timer)
  );

  psl_qual_timer u_fbh_timer (
    .clk (clk),
    .rst (rst),
    .q (fq.timer)
  );

  always_comb begin
    nxt = cur;
    nxt.ack = (avs_read || avs_write) && !cur.ack;
    if (avs_read && !cur.ack) begin
      nxt.rdata = rd_val;
    end
    nxt.tick_cnt = tick ? 24'h00_0000 : cur.tick_cnt + 24'h00_0001;
    if (wr_go) begin
      case (avs_address)
        `PSL_OFF_SLEEP_LVL: nxt.sleep_lvl = wr_val[15:0];
        `PSL_OFF_SLEEP_DLY: nxt.sleep_dly = wr_val[7:0];
        `PSL_OFF_STOP_CFG: begin
          nxt.stop_meth = wr_val[1:0];
          nxt.rev_prohibit = wr_val[`PSL_F_REV_PROHIBIT];
        end
        `PSL_OFF_RAMP: begin
          if (wr_val[7:0] <= `PSL_RAMP_MAX) nxt.ramp_time = wr_val[7:0];
          else nxt.refused = 1'b1;
        end
        `PSL_OFF_TGT_SRC: begin
          nxt.tgt_sel = wr_val[`PSL_F_TGT_SEL];
          nxt.ana_tgt = wr_val[`PSL_F_ANA_TGT];
          nxt.soft_di = wr_val[`PSL_F_SOFT_DI];
        end
        `PSL_OFF_FIXED_TGT: begin
          if (wr_val[15:0] <= `PSL_PCT_FULL) nxt.fixed_tgt = wr_val[15:0];
          else nxt.refused = 1'b1;
        end
        `PSL_OFF_UNITS: nxt.units = wr_val[1:0];
        `PSL_OFF_LOW_LIM: begin
          if ($signed(wr_val[15:0]) <= $signed(`PSL_LOW_LIM_MAX) &&
              $signed(wr_val[15:0]) >= -$signed(`PSL_LOW_LIM_MAX)) begin
            nxt.low_lim = wr_val[15:0];
          end else begin
            nxt.refused = 1'b1;
          end
        end
        `PSL_OFF_IN_LIM: begin
          if (wr_val[15:0] <= `PSL_IN_LIM_MAX) nxt.in_lim = wr_val[15:0];
          else nxt.refused = 1'b1;
        end
        `PSL_OFF_FBH_LVL: begin
          if (wr_val[7:0] <= `PSL_FBH_LVL_MAX) nxt.fbh_lvl = wr_val[7:0];
          else nxt.refused = 1'b1;
        end
        `PSL_OFF_FBH_TIME: nxt.fbh_time = wr_val[7:0];
        `PSL_OFF_DISP_FULL: begin
          if (cur.units == `PSL_UNITS_USER && wr_val[15:0] != 16'h0000 &&
              wr_val[15:0] <= `PSL_DISP_FULL_MAX) begin
            nxt.disp_full = wr_val[15:0];
          end else begin
            nxt.refused = 1'b1;
          end
        end
        `PSL_OFF_DISP_DEC: begin
          if (cur.units == `PSL_UNITS_USER) nxt.disp_dec = wr_val[1:0];
          else nxt.refused = 1'b1;
        end
        `PSL_OFF_MON_SEL: nxt.mon_sel = wr_val[0];
        `PSL_OFF_REV_SEL2: nxt.rev_sel2 = wr_val[0];
        `PSL_OFF_MODE: begin
          nxt.pid_mode = wr_val[2:0];
          nxt.fb_mode = wr_val[`PSL_F_FB_MODE +: 3];
        end
        `PSL_OFF_MAX_FREQ: nxt.max_freq = wr_val[15:0];
        `PSL_OFF_UPPER: nxt.upper = wr_val[15:0];
        `PSL_OFF_STATUS: begin
          if (wr_val[`PSL_F_REFUSED]) nxt.refused = 1'b0;
        end
        default: ;
      endcase
    end
    // sleep entry and exit
    if (!sleep_en) begin
      nxt.sleep = PSL_RUN;
    end else if (sq.expired) begin
      nxt.sleep = sleeping ? PSL_RUN : PSL_SLEEP;
    end
    // target ramp, bypassed by soft-start input or zero time
    if (cur.ramp_time == 8'h00 || cur.soft_di) begin
      nxt.tgt = tgt_src;
    end else if (tick && cur.tgt < tgt_src) begin
      nxt.tgt = (tgt_src - cur.tgt > step) ? cur.tgt + step : tgt_src;
    end else if (tick && cur.tgt > tgt_src) begin
      nxt.tgt = (cur.tgt - tgt_src > step) ? cur.tgt - step : tgt_src;
    end
    if (err > in_lim_x) nxt.pid_in = in_lim_x;
    else if (err < -in_lim_x) nxt.pid_in = -in_lim_x;
    else nxt.pid_in = err;
    nxt.fb_high = fq.expired;
    nxt.stop_req = (nxt.sleep == PSL_SLEEP) || (pid_act && neg_stop);
    nxt.drive_hz = nxt.stop_req ? 16'h0000 : run_hz;
    nxt.reverse = pid_act && rev_ok && neg && !nxt.stop_req;
    nxt.freq_mon = (pid_act && !cur.mon_sel) ? run_hz : freq_cmd;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
      cur.units <= `PSL_RST_UNITS;
      cur.in_lim <= `PSL_RST_IN_LIM;
      cur.fbh_lvl <= `PSL_RST_FBH_LVL;
      cur.fbh_time <= `PSL_RST_FBH_TIME;
      cur.rev_sel2 <= `PSL_RST_REV_SEL2;
      cur.max_freq <= `PSL_RST_MAX_FREQ;
      cur.upper <= `PSL_RST_UPPER;
      cur.disp_full <= `PSL_RST_DISP_FULL;
      cur.disp_dec <= `PSL_RST_DISP_DEC;
      cur.sleep <= PSL_RUN;
    end else begin
      cur <= nxt;
    end
  end

  assign avs_readdata = cur.rdata;
  assign pid_target = cur.tgt;
  assign pid_input = cur.pid_in;
  assign drive_freq = cur.drive_hz;
  assign drive_reverse = cur.reverse;
  assign stop_request = cur.stop_req;
  assign stop_method_select = cur.stop_meth;
  assign freq_ref_monitor = cur.freq_mon;
  assign fb_high_output = cur.fb_high && (cur.fb_mode == `PSL_FB_MODE_MFO);
  assign target_units_code = cur.units;
  assign user_display_fullscale = cur.disp_full;
  assign user_display_decimals = cur.disp_dec;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sleep_entry_a: assert property ($rose(sleeping) |-> $past(below && sleep_en))
    else $error("sleep entered without low level");
  sleep_off_a: assert property (!sleep_en |=> !sleeping)
    else $error("sleep active with zero delay");
  sleep_stop_a: assert property (sleeping |-> stop_request && drive_freq == 16'h0000)
    else $error("sleep without stop request");
  level_clamp_a: assert property (below |-> run_hz < cap)
    else $error("sleep level above clamp");
  ramp_bypass_a: assert property (cur.soft_di |=> pid_target == $past(tgt_src))
    else $error("soft-start input did not bypass ramp");
  low_limit_a: assert property ((!trim && cur.low_lim != 16'h0000) |-> pid_lim >= cur.low_lim)
    else $error("pid output below lower limit");
  input_clamp_a: assert property (1'b1 |=> (pid_input <= $past(in_lim_x)) && (pid_input >= -$past(in_lim_x)))
    else $error("pid input outside bipolar limit");
  fb_release_a: assert property (!fb_cond |=> !cur.fb_high)
    else $error("feedback high not released");
  fb_cause_a: assert property ($rose(cur.fb_high) |-> $past(fb_cond, 2) && $past(fb_cond))
    else $error("feedback high without sustained level");
  disp_lock_a: assert property ((wr_go && avs_address == `PSL_OFF_DISP_DEC && cur.units != `PSL_UNITS_USER) |=> $stable(user_display_decimals))
    else $error("display decimals written while locked");
  monitor_raw_a: assert property ((pid_act && cur.mon_sel) |=> freq_ref_monitor == $past(freq_cmd))
    else $error("monitor not showing raw reference");
  reverse_gate_a: assert property (drive_reverse |-> $past(cur.rev_sel2 && !cur.rev_prohibit && !trim))
    else $error("reverse without permission");

endmodule : psl_supervisor

`default_nettype wire

// ===== test/psl_motor_model.sv
// behavioural motor on the inverter output: speed follows the run command
// assumes drive outputs are registered on clk
`default_nettype none

module psl_motor_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inverter command
  input wire logic [15:0] drive_freq,
  input wire logic drive_reverse,
  input wire logic stop_request,
  // shaft
  output logic signed [16:0] speed
);
  timeunit 1ns;
  timeprecision 1ns;
  // no inertia modelled: a stop shows at once, so any late stop is visible
  always_ff @(posedge clk) begin
    if (rst || stop_request) begin
      speed <= '0;
    end else if (drive_reverse) begin
      speed <= -$signed({1'b0, drive_freq});
    end else begin
      speed <= $signed({1'b0, drive_freq});
    end
  end
endmodule : psl_motor_model

`default_nettype wire

// ===== test/tb_psl_supervisor.sv
// bench for the supervisor: avalon-mm register access plus process inputs
// assumes a short tick (TICK_CYCLES = 10) so timers finish in few cycles
`include "psl_params.svh"
`default_nettype none

module tb_psl_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 10;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0;
  logic [7:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic avs_waitrequest, drive_reverse, stop_request, fb_high_output;
  logic [15:0] freq_cmd = '0, pid_out = '0, feedback = '0, pid_target;
  logic [15:0] drive_freq, freq_ref_monitor, user_display_fullscale;
  logic [17:0] pid_input;
  logic [1:0] stop_method_select, target_units_code, user_display_decimals;
  logic signed [16:0] speed;
  int failures = 0, cmp_count = 0, n;

  psl_supervisor #(.TICK_CYCLES(TK)) psl_supervisor_i (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .freq_cmd(freq_cmd), .pid_out(pid_out), .feedback(feedback),
    .analog_target(16'h04D2), .pid_target(pid_target),
    .pid_input(pid_input), .drive_freq(drive_freq),
    .drive_reverse(drive_reverse), .stop_request(stop_request),
    .stop_method_select(stop_method_select),
    .freq_ref_monitor(freq_ref_monitor), .fb_high_output(fb_high_output),
    .target_units_code(target_units_code),
    .user_display_fullscale(user_display_fullscale),
    .user_display_decimals(user_display_decimals));
  psl_motor_model psl_motor_model_i (.clk(clk), .rst(rst),
    .drive_freq(drive_freq), .drive_reverse(drive_reverse),
    .stop_request(stop_request), .speed(speed));

  always #4 clk = ~clk;

  task summarize;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // request stands until the edge that sees waitrequest low; a hang is
  // left to the watchdog
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task wt(input int c);
    repeat (c) @(posedge clk);
  endtask : wt

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    acc(0, `PSL_OFF_UNITS, 0); chk("units", q, 1);
    chk("units out", target_units_code, 2'h1);
    acc(0, `PSL_OFF_IN_LIM, 0); chk("in_lim", q, 16'h2710);
    acc(0, `PSL_OFF_FBH_LVL, 0); chk("fbh_lvl", q, 8'h64);
    acc(0, `PSL_OFF_FBH_TIME, 0); chk("fbh_time", q, 8'h0A);
    acc(0, `PSL_OFF_REV_SEL2, 0); chk("rev_sel2", q, 1);
    acc(0, 8'h01, 0); chk("unmapped", q, 0);
    acc(1, `PSL_OFF_DISP_FULL, 16'h01F4);
    acc(1, `PSL_OFF_DISP_DEC, 1);
    acc(0, `PSL_OFF_STATUS, 0); chk("refused", q[4], 1);
    chk("dec", user_display_decimals, 2'h2);
    chk("full", user_display_fullscale, 16'h2710);
    acc(1, `PSL_OFF_STATUS, 8'h10);
    acc(1, `PSL_OFF_UNITS, 3);
    acc(1, `PSL_OFF_DISP_FULL, 16'h01F4);
    wt(2); chk("full user", user_display_fullscale, 16'h01F4);
    // fixed target with the analog input not assigned
    acc(1, `PSL_OFF_FIXED_TGT, 16'h1388);
    acc(1, `PSL_OFF_TGT_SRC, 1);
    wt(3 * TK); chk("target", pid_target, 16'h1388);
    // ramp of 0.4 s: 2500 per tick down to zero, then soft-start bypass
    acc(1, `PSL_OFF_RAMP, 4);
    acc(1, `PSL_OFF_FIXED_TGT, 0);
    wt(2); chk("ramp", pid_target >= 16'h09C4, 1);
    wt(3 * TK); chk("ramp end", pid_target, 0);
    acc(1, `PSL_OFF_TGT_SRC, 5);
    acc(1, `PSL_OFF_FIXED_TGT, 16'h1388);
    wt(2); chk("soft", pid_target, 16'h1388);
    acc(1, `PSL_OFF_IN_LIM, 16'h0064);
    wt(3); chk("in clamp", {14'h0, pid_input}, 18'h0_03E8);
    feedback <= 16'h2328;
    wt(3); chk("in clamp n", {14'h0, pid_input}, 18'h3_FC18);
    acc(1, `PSL_OFF_IN_LIM, 16'h2711);
    acc(0, `PSL_OFF_STATUS, 0); chk("in refused", q[4], 1);
    // feedback high: level 100 %, time 2 ticks, restart on an early drop
    acc(1, `PSL_OFF_FBH_TIME, 2);
    feedback <= 16'h2711;
    wt(TK + 2); feedback <= 16'h0000; wt(2);
    feedback <= 16'h2711;
    wt(2 * TK - 2); chk("fbh early", fb_high_output, 0);
    n = 0;
    while (fb_high_output !== 1'b1 && n < 6 * TK) begin wt(1); n++; end
    chk("fbh", fb_high_output, 1);
    feedback <= 16'h0000;
    wt(3); chk("fbh off", fb_high_output, 0);
    // negative pid output in pid mode 1, sleep disabled
    acc(1, `PSL_OFF_MODE, 1);
    freq_cmd <= 16'h0BB8;
    pid_out <= 16'hFF38;
    wt(4); chk("rev", drive_reverse, 1);
    chk("motor", {15'h0000, speed}, 17'h1_FB50);
    acc(1, `PSL_OFF_LOW_LIM, 16'hFF9C);
    wt(4); chk("low lim", drive_freq, 16'h0258);
    acc(1, `PSL_OFF_STOP_CFG, 4);
    wt(4); chk("prohibit", drive_reverse, 0);
    acc(1, `PSL_OFF_STOP_CFG, 2);
    acc(1, `PSL_OFF_REV_SEL2, 0);
    wt(4); chk("neg stop", stop_request, 1);
    chk("neg freq", drive_freq, 0);
    acc(1, `PSL_OFF_MODE, 3);
    wt(4); chk("trim run", stop_request, 0);
    chk("trim dir", drive_reverse, 0);
    chk("trim freq", drive_freq, 16'h0708);
    chk("mon pid", freq_ref_monitor, 16'h0708);
    acc(1, `PSL_OFF_MON_SEL, 1);
    wt(3); chk("mon raw", freq_ref_monitor, 16'h0BB8);
    // sleep with pid off: disabled, clamped level, then real entry
    acc(1, `PSL_OFF_MODE, 0);
    pid_out <= 16'h0000;
    freq_cmd <= 16'h01F4;
    acc(1, `PSL_OFF_SLEEP_LVL, 16'h03E8);
    wt(8 * TK); chk("dly zero", stop_request, 0);
    freq_cmd <= 16'h1964;
    acc(1, `PSL_OFF_SLEEP_LVL, 16'h1B58);
    acc(1, `PSL_OFF_SLEEP_DLY, 2);
    wt(8 * TK); chk("lvl clamp", stop_request, 0);
    acc(1, `PSL_OFF_SLEEP_LVL, 16'h03E8);
    freq_cmd <= 16'h01F4;
    wt(TK + 5); chk("sleep early", stop_request, 0);
    n = 0;
    while (stop_request !== 1'b1 && n < 6 * TK) begin wt(1); n++; end
    chk("sleep", stop_request, 1);
    chk("sleep freq", drive_freq, 0);
    chk("stop meth", stop_method_select, 2'h2);
    wt(2); chk("motor stop", speed, 0);
    freq_cmd <= 16'h0BB8;
    wt(TK + 5); chk("wake early", stop_request, 1);
    n = 0;
    while (stop_request !== 1'b0 && n < 6 * TK) begin wt(1); n++; end
    chk("wake", stop_request, 0);
    summarize();
  end
endmodule : tb_psl_supervisor

`default_nettype wire
